// File: nsp_pkg.sv
// Package: widths, constants and carrier types for the select and overrange block
package nsp_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int SAMPLE_W   = 12;
	localparam int THRESH_W   = 8;
	localparam int PULSE_W    = 4;
	localparam int PHASE_W    = 32;
	localparam int NUM_OSC    = 4;
	localparam int SEL_W      = 2;
	localparam int SYNC_DEPTH = 3;

	// ****************************************
	// Constants
	// ****************************************
	localparam logic        SRC_PINS      = 1'h1;
	localparam logic [1:0]  SEL_RESET     = 2'h0;
	localparam logic [PULSE_W-1:0] PULSE_ONE = 4'h1;
	localparam logic [PULSE_W-1:0] PULSE_ZERO = 4'h0;
	localparam logic [PHASE_W-1:0] PHASE_ZERO = 32'h0000_0000;
	localparam logic [SYNC_DEPTH-1:0] SYNC_ZERO = 3'h0;
	localparam int  SHIFT_MSB_POS = 4;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic msb;
		logic lsb;
	} nsp_sel_pins_s;

	typedef struct packed {
		logic second;
		logic first;
	} nsp_flags_s;

	typedef logic [PHASE_W-1:0] nsp_phase_t;

	typedef enum logic [1:0] {
		NSP_IDLE,
		NSP_HOLD
	} nsp_ovr_e;

endpackage : nsp_pkg

// File: nsp_sync.sv
// Synchroniser: multi-stage capture of asynchronous select pins
module nsp_sync (
	input  wire logic                      clk_sys,
	input  wire logic                      srst,
	input  wire logic                      clk_en,
	input  wire logic [nsp_pkg::SEL_W-1:0] async_in,
	output logic      [nsp_pkg::SEL_W-1:0] sync_out
);

	logic [nsp_pkg::SEL_W-1:0] stage [nsp_pkg::SYNC_DEPTH];

	// R10 - Chained capture stages
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < nsp_pkg::SYNC_DEPTH; i++) begin
				stage[i] <= nsp_pkg::SEL_RESET;
			end
		end else if (clk_en) begin
			stage[0] <= async_in;
			for (int i = 1; i < nsp_pkg::SYNC_DEPTH; i++) begin
				stage[i] <= stage[i-1];
			end
		end
	end

	assign sync_out = stage[nsp_pkg::SYNC_DEPTH-1];

endmodule : nsp_sync

// File: nsp_top.sv
// Oscillator selection and overrange flag logic for two channels
// Behaviour
// R1 - Converter A reads its two select pins as an index, first pin low bit, second pin high bit.
// R2 - Converter B decodes its own select pin pair the same way to pick one of four oscillators.
// R3 - Every oscillator keeps advancing its phase whether selected or not.
// R4 - Selection follows the pins only while the selection source setting is 1.
// R5 - Select pins are accepted as asynchronous with no timing relation to the clock.
// R6 - Channel A first flag rises when its input exceeds the first threshold.
// R7 - Channel A second flag rises when its input exceeds the second threshold.
// R8 - Channel B has its own two flags for the first and second thresholds.
// R9 - A raised flag stays high for at least the programmed pulse length.
// R10 - Select pins pass a multi-stage synchroniser before decoding.
module nsp_top (
	input  wire logic                         clk_sys,
	input  wire logic                         srst,
	input  wire logic                         clk_en,
	input  wire logic                         ddc_a_osc_select_lsb,
	input  wire logic                         ddc_a_osc_select_msb,
	input  wire logic                         ddc_b_osc_select_lsb,
	input  wire logic                         ddc_b_osc_select_msb,
	input  wire logic                         osc_select_source,
	input  wire logic [nsp_pkg::SEL_W-1:0]    reg_sel_a,
	input  wire logic [nsp_pkg::SEL_W-1:0]    reg_sel_b,
	input  wire nsp_pkg::nsp_phase_t          osc_freq_word [nsp_pkg::NUM_OSC],
	input  wire logic [nsp_pkg::SAMPLE_W-1:0] sample_a,
	input  wire logic [nsp_pkg::SAMPLE_W-1:0] sample_b,
	input  wire logic [nsp_pkg::THRESH_W-1:0] over_threshold_first,
	input  wire logic [nsp_pkg::THRESH_W-1:0] over_threshold_second,
	input  wire logic [nsp_pkg::PULSE_W-1:0]  over_pulse_length,
	output logic      [nsp_pkg::SEL_W-1:0]    osc_sel_a,
	output logic      [nsp_pkg::SEL_W-1:0]    osc_sel_b,
	output nsp_pkg::nsp_phase_t               mix_phase_a,
	output nsp_pkg::nsp_phase_t               mix_phase_b,
	output logic                              chan_a_over_flag_first,
	output logic                              chan_a_over_flag_second,
	output logic                              chan_b_over_flag_first,
	output logic                              chan_b_over_flag_second
);

	// ****************************************
	// Functions
	// ****************************************
	// Magnitude of a signed sample, top bits compared with a threshold
	function automatic logic exceeds(input logic [nsp_pkg::SAMPLE_W-1:0] s,
		input logic [nsp_pkg::THRESH_W-1:0] t);
		logic [nsp_pkg::SAMPLE_W-1:0] mag;
		mag = s[nsp_pkg::SAMPLE_W-1] ? ~s : s;
		return mag[nsp_pkg::SAMPLE_W-2 -: nsp_pkg::THRESH_W] > t;
	endfunction : exceeds

	// ****************************************
	// Select synchronisers
	// ****************************************
	nsp_pkg::nsp_sel_pins_s pins_a;
	nsp_pkg::nsp_sel_pins_s pins_b;
	logic [nsp_pkg::SEL_W-1:0] sync_a;
	logic [nsp_pkg::SEL_W-1:0] sync_b;

	// R1 - Pin pair to index A
	assign pins_a = '{msb: ddc_a_osc_select_msb, lsb: ddc_a_osc_select_lsb};
	// R2 - Pin pair to index B
	assign pins_b = '{msb: ddc_b_osc_select_msb, lsb: ddc_b_osc_select_lsb};

	// R5 - Async pins into sync chain
	nsp_sync u_sync_a (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.clk_en   (clk_en),
		.async_in (pins_a),
		.sync_out (sync_a)
	);

	nsp_sync u_sync_b (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.clk_en   (clk_en),
		.async_in (pins_b),
		.sync_out (sync_b)
	);

	// ****************************************
	// Selection
	// ****************************************
	logic [nsp_pkg::SEL_W-1:0] next_sel_a;
	logic [nsp_pkg::SEL_W-1:0] next_sel_b;

	// R4 - Pins only when source is 1
	assign next_sel_a = (osc_select_source == nsp_pkg::SRC_PINS) ? sync_a : reg_sel_a;
	assign next_sel_b = (osc_select_source == nsp_pkg::SRC_PINS) ? sync_b : reg_sel_b;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			osc_sel_a <= nsp_pkg::SEL_RESET;
			osc_sel_b <= nsp_pkg::SEL_RESET;
		end else if (clk_en) begin
			osc_sel_a <= next_sel_a;
			osc_sel_b <= next_sel_b;
		end
	end

	// ****************************************
	// Oscillator bank
	// ****************************************
	nsp_pkg::nsp_phase_t phase_a [nsp_pkg::NUM_OSC];
	nsp_pkg::nsp_phase_t phase_b [nsp_pkg::NUM_OSC];

	// R3 - All phases advance on every cycle with clk_en high, selected or not
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < nsp_pkg::NUM_OSC; i++) begin
				phase_a[i] <= nsp_pkg::PHASE_ZERO;
				phase_b[i] <= nsp_pkg::PHASE_ZERO;
			end
		end else if (clk_en) begin
			for (int i = 0; i < nsp_pkg::NUM_OSC; i++) begin
				phase_a[i] <= phase_a[i] + osc_freq_word[i];
				phase_b[i] <= phase_b[i] + osc_freq_word[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mix_phase_a <= nsp_pkg::PHASE_ZERO;
			mix_phase_b <= nsp_pkg::PHASE_ZERO;
		end else if (clk_en) begin
			mix_phase_a <= phase_a[osc_sel_a];
			mix_phase_b <= phase_b[osc_sel_b];
		end
	end

	// ****************************************
	// Overrange detection
	// ****************************************
	nsp_pkg::nsp_flags_s hit_a;
	nsp_pkg::nsp_flags_s hit_b;
	logic [3:0] hit;
	logic [3:0] flag;
	logic [nsp_pkg::PULSE_W-1:0] hold_cnt [4];

	// R6 - A over first threshold
	assign hit_a.first  = exceeds(sample_a, over_threshold_first);
	// R7 - A over second threshold
	assign hit_a.second = exceeds(sample_a, over_threshold_second);
	// R8 - B pair of thresholds
	assign hit_b.first  = exceeds(sample_b, over_threshold_first);
	assign hit_b.second = exceeds(sample_b, over_threshold_second);
	assign hit = {hit_b.second, hit_b.first, hit_a.second, hit_a.first};

	// R9 - Stretch to pulse length
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < 4; i++) begin
				hold_cnt[i] <= nsp_pkg::PULSE_ZERO;
				flag[i]     <= 1'b0;
			end
		end else if (clk_en) begin
			for (int i = 0; i < 4; i++) begin
				if (hit[i]) begin
					hold_cnt[i] <= over_pulse_length;
					flag[i]     <= 1'b1;
				end else if (hold_cnt[i] > nsp_pkg::PULSE_ONE) begin
					hold_cnt[i] <= hold_cnt[i] - nsp_pkg::PULSE_ONE;
				end else begin
					hold_cnt[i] <= nsp_pkg::PULSE_ZERO;
					flag[i]     <= 1'b0;
				end
			end
		end
	end

	assign chan_a_over_flag_first  = flag[0];
	assign chan_a_over_flag_second = flag[1];
	assign chan_b_over_flag_first  = flag[2];
	assign chan_b_over_flag_second = flag[3];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	a_hit_raises_flag_a0: assert property (clk_en && hit_a.first |=> chan_a_over_flag_first) // R6
		else $error("Channel A first flag not raised");
	a_hit_raises_flag_a1: assert property (clk_en && hit_a.second |=> chan_a_over_flag_second) // R7
		else $error("Channel A second flag not raised");
	a_hit_raises_flag_b: assert property (clk_en && hit_b.first |=> chan_b_over_flag_first) // R8
		else $error("Channel B first flag not raised");
	a_flag_hold_min: assert property (clk_en && hit[0] && over_pulse_length == 4'h3
		##1 clk_en [*2] |-> chan_a_over_flag_first) // R9
		else $error("Flag dropped before pulse length");
	a_pin_select_path: assert property (clk_en && osc_select_source [*5] |-> osc_sel_a == $past(sync_a)) // R4
		else $error("Pin selection not followed");
	a_reg_select_path: assert property (clk_en && !osc_select_source |=> osc_sel_b == $past(reg_sel_b)) // R4
		else $error("Register selection not followed");
	a_sync_latency: assert property ((clk_en && osc_select_source && $stable(pins_a)) [*4]
		|=> osc_sel_a == $past(pins_a, 4)) // R10
		else $error("Synchroniser latency wrong");
	a_phase_advance: assert property (clk_en |=> phase_a[2] == $past(phase_a[2]) + $past(osc_freq_word[2])) // R3
		else $error("Unselected oscillator stalled");
	a_mix_tracks_sel: assert property (clk_en |=> mix_phase_b == $past(phase_b[osc_sel_b])) // R2
		else $error("Mixer phase not from selected oscillator");

	// R8 - Channel B second flag
	a_hit_raises_flag_b1: assert property (clk_en && hit_b.second |=> chan_b_over_flag_second) // R8
		else $error("Channel B second flag not raised");

	// R9 - Flag falls once hold expires
	a_flag_release: assert property (clk_en && !hit[0] && hold_cnt[0] <= nsp_pkg::PULSE_ONE
		|=> !chan_a_over_flag_first) // R9
		else $error("Flag held past pulse length");

	// R3 - Frozen while enable low
	a_freeze_phase: assert property (!clk_en |=> mix_phase_a == $past(mix_phase_a)) // R3
		else $error("Phase moved while enable low");

	// R4 - Selection frozen while enable low
	a_freeze_select: assert property (!clk_en |=> osc_sel_a == $past(osc_sel_a)) // R4
		else $error("Selection moved while enable low");

	c_flag_stretch: cover property (hit[1] ##1 !hit[1] ##1 chan_a_over_flag_second);
	c_pin_switch: cover property (osc_select_source && osc_sel_a != $past(osc_sel_a));
	c_reg_mode: cover property (!osc_select_source && osc_sel_b == 2'h3);
	c_freeze: cover property (!clk_en ##1 !clk_en);
	c_b_flags: cover property (chan_b_over_flag_first && chan_b_over_flag_second);

endmodule : nsp_top

// File: nsp_host_model.sv
// Host model: drives the select pins off the sampling edge
module nsp_host_model (
	input  wire logic       clk_sys,
	input  wire logic [1:0] want_a,
	input  wire logic [1:0] want_b,
	output logic            ddc_a_osc_select_lsb,
	output logic            ddc_a_osc_select_msb,
	output logic            ddc_b_osc_select_lsb,
	output logic            ddc_b_osc_select_msb
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {ddc_a_osc_select_msb, ddc_a_osc_select_lsb, ddc_b_osc_select_msb, ddc_b_osc_select_lsb} = 4'h0;
	// pins change 3 ns after the edge
	always @(posedge clk_sys) begin
		#3;
		{ddc_a_osc_select_msb, ddc_a_osc_select_lsb} <= want_a;
		{ddc_b_osc_select_msb, ddc_b_osc_select_lsb} <= want_b;
	end
endmodule : nsp_host_model

// File: test_nsp_top.sv
// Testbench: select pins, phase continuity and overrange flags
module test_nsp_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                clk_sys = 1'b0;
	logic                srst = 1'b1;
	logic                src = 1'b0;
	logic                en = 1'b1;
	logic [1:0]          reg_sel_a = 2'h0, reg_sel_b = 2'h0, want_a = 2'h0, want_b = 2'h0;
	logic [11:0]         sample_a = 12'h000, sample_b = 12'h000;
	logic [3:0]          plen = 4'h0;
	nsp_pkg::nsp_phase_t freq [nsp_pkg::NUM_OSC] = '{32'h0000_1000, 32'h0012_3457, 32'h0100_0003, 32'h1000_0101};
	nsp_pkg::nsp_phase_t ph_a, ph_b, p;
	logic                pa0, pa1, pb0, pb1, fa0, fa1, fb0, fb1;
	logic [1:0]          sel_a, sel_b;
	int                  fails = 0, num_checks = 0;
	int                  hits [4];
	always #5 clk_sys = ~clk_sys;
	nsp_host_model host (.clk_sys(clk_sys), .want_a(want_a), .want_b(want_b), .ddc_a_osc_select_lsb(pa0),
		.ddc_a_osc_select_msb(pa1), .ddc_b_osc_select_lsb(pb0), .ddc_b_osc_select_msb(pb1));
	nsp_top dut (.clk_sys(clk_sys), .srst(srst), .clk_en(en), .ddc_a_osc_select_lsb(pa0),
		.ddc_a_osc_select_msb(pa1), .ddc_b_osc_select_lsb(pb0), .ddc_b_osc_select_msb(pb1),
		.osc_select_source(src), .reg_sel_a(reg_sel_a), .reg_sel_b(reg_sel_b), .osc_freq_word(freq),
		.sample_a(sample_a), .sample_b(sample_b), .over_threshold_first(8'h10), .over_threshold_second(8'h40),
		.over_pulse_length(plen), .osc_sel_a(sel_a), .osc_sel_b(sel_b), .mix_phase_a(ph_a), .mix_phase_b(ph_b),
		.chan_a_over_flag_first(fa0), .chan_a_over_flag_second(fa1), .chan_b_over_flag_first(fb0),
		.chan_b_over_flag_second(fb1));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [31:0] act, input logic [31:0] exp);
		num_checks++;
		if (act !== exp) begin
			fails++;
			$display("wrong value at %0t: got %0h want %0h", $time, act, exp);
		end
	endtask : chk
	task automatic set_sel(input logic s, input logic [1:0] a, input logic [1:0] b, input logic [1:0] ra,
		input logic [1:0] rb);
		@(posedge clk_sys);
		src <= s;
		want_a <= a;
		want_b <= b;
		reg_sel_a <= ra;
		reg_sel_b <= rb;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : set_sel
	task automatic pulse(input logic [11:0] sa, input logic [11:0] sb, input logic [3:0] n);
		hits = '{default: 0};
		@(posedge clk_sys);
		plen <= n;
		@(posedge clk_sys);
		sample_a <= sa;
		sample_b <= sb;
		@(posedge clk_sys);
		sample_a <= 12'h000;
		sample_b <= 12'h000;
		repeat (24) begin
			@(negedge clk_sys);
			hits[0] += int'(fa0 === 1'b1);
			hits[1] += int'(fa1 === 1'b1);
			hits[2] += int'(fb0 === 1'b1);
			hits[3] += int'(fb1 === 1'b1);
		end
	endtask : pulse
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#20000;
		fails++;
		report_and_stop();
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		@(negedge clk_sys);
		chk({sel_a, sel_b, fa0, fa1, fb0, fb1}, 32'h0);
		for (int i = 0; i < 4; i++) begin
			set_sel(1'b1, 2'(i), 2'(3 - i), 2'h0, 2'h0);
			chk(sel_a, 32'(i));
			chk(sel_b, 32'(3 - i));
		end
		@(posedge clk_sys);
		want_a <= 2'h0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(sel_a, 32'h3);
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(sel_a, 32'h0);
		set_sel(1'b0, 2'h3, 2'h3, 2'h1, 2'h2);
		chk({sel_a, sel_b}, 32'h6);
		set_sel(1'b1, 2'h1, 2'h1, 2'h2, 2'h0);
		chk(ph_a, ph_b);
		p = ph_a;
		@(negedge clk_sys);
		chk(ph_a - p, freq[1]);
		@(posedge clk_sys);
		en <= 1'b0;
		@(negedge clk_sys);
		p = ph_a;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(ph_a, p);
		@(posedge clk_sys);
		en <= 1'b1;
		pulse(12'h100, 12'h300, 4'h3);
		chk(hits[0], 32'h3);
		chk(hits[1], 32'h0);
		chk(hits[2] * 16 + hits[3], 32'h33);
		pulse(12'hEFF, 12'h081, 4'h0);
		chk(hits[0], 32'h1);
		chk(hits[2], 32'h0);
		pulse(12'hC00, 12'h000, 4'hF);
		chk(hits[1], 32'hF);
		chk(hits[0], 32'hF);
		report_and_stop();
	end
endmodule : test_nsp_top
